//--- verilog/pll_cfg_pkg.sv
// constants and field layout of the pll divider and clock select word
package pll_cfg_pkg;

    // ==========================================================
    // register map
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] CFG_WORD0_OFS  = 12'h000;
    localparam logic [31:0] CFG_WORD0_RST  = 32'hBB8A_802A;
    localparam logic [31:0] RD_ZERO        = 32'h0000_0000;
    localparam int          WORD_LSB       = 2;

    // ==========================================================
    // field layout, msb first
    typedef struct packed {
        logic       mclk_div_b_lo;    // memory clock divider_b line 0
        logic [3:0] mclk_div_a;       // memory clock divider_a
        logic [3:0] fab_div_c;        // fabric_clock divider_c
        logic [3:0] fab_div_b;        // fabric_clock divider_b
        logic [3:0] fab_div_a;        // fabric_clock divider_a
        logic [3:0] core_div_c;       // core_clock divider_c
        logic [3:0] core_div_b;       // core_clock divider_b
        logic [3:0] core_div_a;       // core_clock divider_a
        logic [2:0] core_clk_sel;     // one-hot core_clock source select
    } pll_word_s;

    // write mask: only the source select bits are writable
    localparam logic [31:0] CFG_WR_MASK    = 32'h0000_0007;

    // ==========================================================
    // one-hot source select positions
    localparam int SEL_PLL_OUTPUT_B = 0;
    localparam int SEL_PLL_OUTPUT_C = 1;
    localparam int SEL_ALT_FABRIC   = 2;

endpackage

//--- verilog/pll_clock_config_word.sv
// apb-reached pll divider and core clock select configuration word
`timescale 1ns/1ps
// Notes on behaviour
// - memory clock divider_b line 0 comes from word bit 31.
// - memory clock divider_b lines 3:1 come from bits 2:0 of the second word.
// - memory clock divider_a comes from word bits 30:27.
// - fabric_clock divider_c, divider_b, divider_a come from bits 26:23, 22:19, 18:15.
// - core_clock divider_c, divider_b, divider_a come from bits 14:11, 10:7, 6:3.
// - word bits 2:0 drive the core_clock source select bus.
// - select bit 0 picks pll_output_b, bit 1 pll_output_c, bit 2 alternate_fabric_clock.
// - the host can read and write the three select bits.
// - all divider bits 31:3 are readable and not writable.
// - the word sits at offset 0x000 and loads 0xBB8A802A at reset.
// - the host writes whole words and every read returns all 32 bits.
module pll_clock_config_word
    import pll_cfg_pkg::*;
(
    input  wire logic              clk,               // apb clock, 40 MHz
    input  wire logic              sys_rst,           // synchronous reset, active high
    input  wire logic              psel,              // apb select
    input  wire logic              penable,           // apb access phase
    input  wire logic              pwrite,            // apb write
    input  wire logic [ADDR_W-1:0] paddr,             // apb byte address
    input  wire logic [31:0]       pwdata,            // apb write data
    output logic      [31:0]       prdata,            // apb read data
    output logic                   pready,            // apb ready
    output logic                   pslverr,           // apb error, write to unused word
    input  wire logic [2:0]        mclk_div_b_hi,     // divider_b lines 3:1 from second word
    output logic      [3:0]        mclk_div_b,        // memory clock divider_b bus
    output logic      [3:0]        mclk_div_a,        // memory clock divider_a bus
    output logic      [3:0]        fab_div_c,         // fabric_clock divider_c bus
    output logic      [3:0]        fab_div_b,         // fabric_clock divider_b bus
    output logic      [3:0]        fab_div_a,         // fabric_clock divider_a bus
    output logic      [3:0]        core_div_c,        // core_clock divider_c bus
    output logic      [3:0]        core_div_b,        // core_clock divider_b bus
    output logic      [3:0]        core_div_a,        // core_clock divider_a bus
    output logic      [2:0]        core_clk_sel,      // core_clock source select bus
    output logic                   use_pll_output_b,  // core_clock mux picks pll_output_b
    output logic                   use_pll_output_c,  // core_clock mux picks pll_output_c
    output logic                   use_alt_fabric     // core_clock mux picks alternate_fabric_clock
);

    // ==========================================================
    // state
    pll_word_s   cfg_r;
    pll_word_s   cfg_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // ==========================================================
    // apb decode
    wire         hit_word0  = (paddr[ADDR_W-1:WORD_LSB] == CFG_WORD0_OFS[ADDR_W-1:WORD_LSB]);
    wire         setup_rd   = psel && !penable && !pwrite;
    wire         access_wr  = psel && penable && pwrite;
    wire         wr_word0   = access_wr && hit_word0;
    wire [31:0]  cfg_word   = cfg_r;

    // only the select bits take the write data, dividers keep their value
    assign cfg_nxt   = wr_word0 ? pll_word_s'((cfg_word & ~CFG_WR_MASK)
                                            | (pwdata & CFG_WR_MASK))
                                : cfg_r;
    // read data captured in the setup phase, unused words read zero
    assign rdata_nxt = setup_rd ? (hit_word0 ? cfg_word : RD_ZERO) : rdata_r;

    // no wait states: every access phase ends on its first edge
    // pslverr only answers a write that misses the word, reads never fail
    assign pready    = 1'b1;
    assign pslverr   = access_wr && !hit_word0;
    assign prdata    = rdata_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r   <= pll_word_s'(CFG_WORD0_RST);
            rdata_r <= RD_ZERO;
        end else begin
            cfg_r   <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // divider and select buses
    assign mclk_div_b       = {mclk_div_b_hi, cfg_r.mclk_div_b_lo};
    assign mclk_div_a       = cfg_r.mclk_div_a;
    assign fab_div_c        = cfg_r.fab_div_c;
    assign fab_div_b        = cfg_r.fab_div_b;
    assign fab_div_a        = cfg_r.fab_div_a;
    assign core_div_c       = cfg_r.core_div_c;
    assign core_div_b       = cfg_r.core_div_b;
    assign core_div_a       = cfg_r.core_div_a;
    assign core_clk_sel     = cfg_r.core_clk_sel;
    // one-hot use relies on the host never writing zero or several bits
    assign use_pll_output_b = cfg_r.core_clk_sel[SEL_PLL_OUTPUT_B];
    assign use_pll_output_c = cfg_r.core_clk_sel[SEL_PLL_OUTPUT_C];
    assign use_alt_fabric   = cfg_r.core_clk_sel[SEL_ALT_FABRIC];

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_value_load: assert property ($past(sys_rst) |-> cfg_word == CFG_WORD0_RST)
        else $error("word not at reset value after reset");

    a_select_write_takes: assert property (
        psel && penable && pwrite && hit_word0 |=> core_clk_sel == $past(pwdata[2:0]))
        else $error("select bits did not take write data");

    a_dividers_hold: assert property ($stable(cfg_word[31:3]))
        else $error("divider field changed after reset");

    a_write_keeps_div: assert property (
        psel && penable && pwrite |=> cfg_word[31:3] == CFG_WORD0_RST[31:3])
        else $error("write disturbed divider fields");

    a_read_full_word: assert property (
        psel && !penable && !pwrite && hit_word0 |=> prdata == $past(cfg_word))
        else $error("read did not return the whole word");

    a_unused_read_zero: assert property (
        psel && !penable && !pwrite && !hit_word0 |=> prdata == RD_ZERO)
        else $error("unused word read not zero");

    a_mclk_b_map: assert property (mclk_div_b == {mclk_div_b_hi, cfg_word[31]})
        else $error("memory divider_b bus mismatch");

    a_div_fields_map: assert property (
        {mclk_div_a, fab_div_c, fab_div_b, fab_div_a, core_div_c, core_div_b,
         core_div_a} == cfg_word[30:3])
        else $error("divider bus mismatch");

    a_select_one_hot: assert property (
        {use_alt_fabric, use_pll_output_c, use_pll_output_b} == cfg_word[2:0])
        else $error("source select decode mismatch");

    a_bad_write_err: assert property (
        psel && penable && pwrite && !hit_word0 |-> pslverr ##1 $stable(cfg_word))
        else $error("write to unused word not refused");

    // ==========================================================
    // checks: bus response

    a_ready_in_access: assert property (psel && penable |-> pready)
        else $error("access phase not completed in one cycle");

    a_setup_no_err: assert property (psel && !penable |-> !pslverr)
        else $error("error raised outside the access phase");

    a_read_no_err: assert property (psel && penable && !pwrite |-> !pslverr)
        else $error("read answered with an error");

    a_word_write_ok: assert property (wr_word0 |-> !pslverr)
        else $error("write to the word answered with an error");

    a_err_only_miss: assert property (pslverr |-> access_wr && !hit_word0)
        else $error("error raised for something other than a missed write");

    a_rdata_after_rst: assert property ($past(sys_rst) |-> prdata == RD_ZERO)
        else $error("read data not cleared by reset");

    a_rdata_holds: assert property (!setup_rd |=> $stable(prdata))
        else $error("read data moved without a read setup");

    a_read_sel_bits: assert property (
        setup_rd && hit_word0 |=> (prdata & CFG_WR_MASK) == 32'(core_clk_sel))
        else $error("read data select bits differ from the select bus");

    // ==========================================================
    // checks: divider buses

    a_div_out_stable: assert property (
        $stable({mclk_div_a, fab_div_c, fab_div_b, fab_div_a, core_div_c, core_div_b,
                 core_div_a}))
        else $error("divider bus moved after reset");

    a_mclk_lo_stable: assert property ($stable(mclk_div_b[0]))
        else $error("memory divider_b line 0 moved after reset");

    a_div_reset_value: assert property (
        $past(sys_rst) |-> {mclk_div_a, fab_div_c, fab_div_b, fab_div_a, core_div_c,
                            core_div_b, core_div_a} == CFG_WORD0_RST[30:3])
        else $error("divider buses not at power-up value");

    a_mclk_lo_reset: assert property (
        $past(sys_rst) |-> mclk_div_b[0] == CFG_WORD0_RST[31])
        else $error("memory divider_b line 0 not at power-up value");

    // ==========================================================
    // checks: core_clock source select

    a_sel_onehot: assert property ($onehot(core_clk_sel))
        else $error("core_clock source select not one-hot");

    a_mux_one_pick: assert property (
        $onehot({use_alt_fabric, use_pll_output_c, use_pll_output_b}))
        else $error("core_clock mux picks other than one source");

    a_sel_hold_idle: assert property (!wr_word0 |=> $stable(core_clk_sel))
        else $error("select bus moved without a write");

    a_sel_reset_value: assert property (
        $past(sys_rst) |-> core_clk_sel == CFG_WORD0_RST[2:0])
        else $error("select bus not at power-up value");

    a_mux_reset_pick: assert property (
        $past(sys_rst) |-> {use_alt_fabric, use_pll_output_c, use_pll_output_b}
                           == CFG_WORD0_RST[2:0])
        else $error("core_clock mux not on its power-up source");

    a_pick_b_write: assert property (
        wr_word0 |=> use_pll_output_b == $past(pwdata[SEL_PLL_OUTPUT_B]))
        else $error("write did not steer the pll_output_b pick");

    a_pick_c_write: assert property (
        wr_word0 |=> use_pll_output_c == $past(pwdata[SEL_PLL_OUTPUT_C]))
        else $error("write did not steer the pll_output_c pick");

    a_pick_alt_write: assert property (
        wr_word0 |=> use_alt_fabric == $past(pwdata[SEL_ALT_FABRIC]))
        else $error("write did not steer the alternate_fabric_clock pick");

endmodule

//--- verification/apb_host.sv
// apb host model driving the configuration word bus
`timescale 1ns/1ps
module apb_host (
    input  wire logic        clk,     // bus clock
    output logic             psel,    // select
    output logic             penable, // access phase
    output logic             pwrite,  // write
    output logic [11:0]      paddr,   // byte address
    output logic [31:0]      pwdata,  // write data
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // ready
    input  wire logic        pslverr  // error
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = {3'h0, 12'h000, 32'h0000_0000};
    end
    // whole-word transfer; released address and data lines show inverted values
    task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(negedge clk);
        {psel, penable, pwrite, paddr, pwdata} = {2'h2, we, a, wd};
        @(negedge clk);
        penable = 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        @(negedge clk);
        {psel, penable, paddr, pwdata} = {2'h0, ~a, ~wd};
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the pll divider and clock select word
`timescale 1ns/1ps
module testbench
    import pll_cfg_pkg::*;
;
    localparam logic [31:0] R = CFG_WORD0_RST;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, ub, uc, ua;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  hi, cs, sel;
    logic [3:0]  mb, ma, fc, fb, fa, cc, cb, ca;
    int          fail_count, check_count;
    int          cyc = 0;
    apb_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pll_clock_config_word i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mclk_div_b_hi(hi), .mclk_div_b(mb),
        .mclk_div_a(ma), .fab_div_c(fc), .fab_div_b(fb), .fab_div_a(fa), .core_div_c(cc),
        .core_div_b(cb), .core_div_a(ca), .core_clk_sel(cs), .use_pll_output_b(ub),
        .use_pll_output_c(uc), .use_alt_fabric(ua));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, tests need well under 200 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end
    initial begin
        {sys_rst, hi, fail_count, check_count} = {1'b1, 3'h5, 32'h0000_0000, 32'h0000_0000};
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        i_host.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
        chk("reset word", rd, R);
        chk("read error", 32'(err), 32'h0000_0000);
        chk("ready", 32'(pready), 32'h0000_0001);
        chk("mclk_div_b", 32'(mb), 32'({hi, R[31]}));
        hi = 3'h2;
        #1 chk("mclk_div_b upper", 32'(mb), 32'({3'h2, R[31]}));
        chk("mclk_div_a", 32'(ma), 32'(R[30:27]));
        chk("fabric dividers", 32'({fc, fb, fa}), 32'(R[26:15]));
        chk("core dividers", 32'({cc, cb, ca}), 32'(R[14:3]));
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            sel = 3'h1 << i;
            i_host.xfer(1'b1, 12'h000, {29'h1FFF_FFFF, sel}, rd, err);
            chk("write error", 32'(err), 32'h0000_0000);
            chk("select bus", 32'(cs), 32'(sel));
            chk("mux picks", 32'({ua, uc, ub}), 32'(sel));
            chk("dividers held", 32'({ma, fc, fb, fa, cc, cb, ca}), 32'(R[30:3]));
            i_host.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
            chk("readback", rd, {R[31:3], sel});
        end
        $display("test select done");
        i_host.xfer(1'b1, 12'h004, 32'h0000_0001, rd, err);
        chk("unused write error", 32'(err), 32'h0000_0001);
        i_host.xfer(1'b0, 12'h008, 32'h0000_0000, rd, err);
        chk("unused read", rd, 32'h0000_0000);
        chk("unused read error", 32'(err), 32'h0000_0000);
        i_host.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
        chk("word kept", rd, {R[31:3], 3'h4});
        $display("test unused done");
        conclude();
    end
endmodule
